// >>> verilog/cdcme_pkg.sv
// Shared constants for the converter mode and error reporting registers
`default_nettype none
package cdcme_pkg;
  // Register pointers
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_ERRCFG = 8'h19;
  localparam logic [7:0] REG_CONFIG = 8'h1a;
  localparam logic [7:0] REG_MUX = 8'h1b;
  // Reset values
  localparam logic [15:0] ERRCFG_RST = 16'h0000;
  localparam logic [15:0] CONFIG_RST = 16'h2801;
  localparam logic [15:0] MUX_RST = 16'h020f;
  // Error reporting control fields
  localparam int WD_TO_RESULT_BIT = 13;
  localparam int AH_TO_RESULT_BIT = 12;
  localparam int AL_TO_RESULT_BIT = 11;
  localparam int WD_TO_IRQ_BIT = 5;
  localparam int RDY_TO_IRQ_BIT = 0;
  // Operating setup fields
  localparam int CHSEL_HI = 15;
  localparam int CHSEL_LO = 14;
  localparam int SLEEP_BIT = 13;
  localparam int ACT_STYLE_BIT = 11;
  localparam int REF_SRC_BIT = 9;
  localparam int IRQ_MASK_BIT = 7;
  localparam int BOOST_BIT = 6;
  // Scan setup fields
  localparam int SEQ_EN_BIT = 15;
  localparam int ORDER_HI = 14;
  localparam int ORDER_LO = 13;
  // Status fields
  localparam int ST_CHAN_LO = 14;
  localparam int ST_WD_BIT = 11;
  localparam int ST_RDY_BIT = 6;
  // Scan order codes
  localparam logic [1:0] ORDER_TWO = 2'h0;
  localparam logic [1:0] ORDER_THREE = 2'h1;
  localparam logic [1:0] ORDER_FOUR = 2'h2;
  // Serial bus
  localparam logic [6:0] BUS_ADDR_DEFAULT = 7'h2a; // Arbitrary default
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  typedef enum logic [5:0] {
    CDCME_IDLE = 6'h01,
    CDCME_ADDR = 6'h02,
    CDCME_RX = 6'h04,
    CDCME_ACK = 6'h08,
    CDCME_TX = 6'h10,
    CDCME_RACK = 6'h20
  } cdcme_state_e;
endpackage
`default_nettype wire

// >>> verilog/cdcme_regs.sv
// Mode and error reporting control registers with serial register port
`default_nettype none
module cdcme_regs
  import cdcme_pkg::*;
#(
  parameter logic [6:0] BUS_ADDR = BUS_ADDR_DEFAULT
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Serial register pins
  input wire logic scl_pin,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Events from the conversion core
  input wire logic conv_done,
  input wire logic watchdog_evt,
  input wire logic amp_high_evt,
  input wire logic amp_low_evt,
  input wire logic [1:0] event_chan,
  input wire logic result_read,
  input wire logic [1:0] result_read_chan,
  // Result word flags
  output logic [3:0] result_watchdog_flag,
  output logic [3:0] result_amplitude_flag,
  // Mode outputs
  output logic [1:0] conv_channel,
  output logic sleep_active,
  output logic full_current_activation,
  output logic reference_source_select,
  output logic boost_drive_ch0_en,
  // Interrupt pin
  output logic irq_n_pin
);
  // Last channel of a scan order
  function automatic logic [1:0] last_chan(input logic [1:0] order);
    unique case (order)
      ORDER_THREE: last_chan = 2'h2;
      ORDER_FOUR: last_chan = 2'h3;
      default: last_chan = 2'h1;
    endcase
  endfunction

  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  cdcme_state_e st_reg, st_next;
  logic [7:0] sh_reg, sh_next, ptr_reg, ptr_next, msb_reg, msb_next, tx_reg, tx_next;
  logic [7:0] lsb_reg, lsb_next;
  logic [3:0] bit_reg, bit_next;
  logic [1:0] byte_reg, byte_next;
  logic rw_reg, rw_next, rack_reg, rack_next, oe_reg, oe_next;
  logic wr_reg, wr_next, rd_reg, rd_next;
  logic [15:0] errcfg_reg, errcfg_next, config_reg, config_next, mux_reg, mux_next;
  logic [3:0] rwd_reg, rwd_next, ramp_reg, ramp_next;
  logic swd_reg, swd_next, srdy_reg, srdy_next, latched_reg, latched_next;
  logic [1:0] echan_reg, echan_next, ch_reg, ch_next;
  logic irq_reg, irq_next, sleep_reg, full_reg, ref_reg, boost_reg;
  logic start, stop, rise, fall, err_clr;
  logic [15:0] rdata;

  // Pin synchronisers plus one history stage
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
    end else begin
      {scl_m, scl_s, scl_d} <= {scl_pin, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {sda_in, sda_m, sda_s};
    end
  end

  assign start = scl_s & scl_d & sda_d & ~sda_s;
  assign stop = scl_s & scl_d & ~sda_d & sda_s;
  assign rise = scl_s & ~scl_d;
  assign fall = ~scl_s & scl_d;

  // Read data selection
  always_comb begin
    rdata = 16'h0000;
    unique case (ptr_reg)
      REG_STATUS: begin
        rdata[ST_CHAN_LO +: 2] = echan_reg;
        rdata[ST_WD_BIT] = swd_reg;
        rdata[ST_RDY_BIT] = srdy_reg;
      end
      REG_ERRCFG: rdata = errcfg_reg;
      REG_CONFIG: rdata = config_reg;
      REG_MUX: rdata = mux_reg;
      default: rdata = 16'h0000;
    endcase
  end

  // Serial slave next state: pointer, then MSB and LSB of each word
  always_comb begin
    st_next = st_reg;
    sh_next = sh_reg;
    ptr_next = ptr_reg;
    msb_next = msb_reg;
    tx_next = tx_reg;
    lsb_next = lsb_reg;
    bit_next = bit_reg;
    byte_next = byte_reg;
    rw_next = rw_reg;
    rack_next = rack_reg;
    oe_next = oe_reg;
    wr_next = 1'b0;
    rd_next = 1'b0;
    if (stop) begin
      st_next = CDCME_IDLE;
      oe_next = 1'b1;
    end else if (start) begin
      st_next = CDCME_ADDR;
      bit_next = 4'h0;
      byte_next = 2'h0;
      oe_next = 1'b1;
    end else begin
      unique case (st_reg)
        CDCME_IDLE: oe_next = 1'b1;
        CDCME_ADDR, CDCME_RX: begin
          if (rise && bit_reg < BITS_PER_BYTE) begin
            sh_next = {sh_reg[6:0], sda_s};
            bit_next = bit_reg + 4'h1;
          end else if (fall && bit_reg == BITS_PER_BYTE) begin
            st_next = CDCME_ACK;
            oe_next = 1'b0;
            if (st_reg == CDCME_ADDR) begin
              rw_next = sh_reg[0];
              if (sh_reg[7:1] != BUS_ADDR) begin
                st_next = CDCME_IDLE;
                oe_next = 1'b1;
              end
            end else begin
              if (byte_reg == 2'h0) ptr_next = sh_reg;
              if (byte_reg == 2'h1) msb_next = sh_reg;
              wr_next = (byte_reg == 2'h2);
              byte_next = (byte_reg == 2'h2) ? 2'h1 : byte_reg + 2'h1;
            end
          end
        end
        CDCME_ACK: begin
          if (fall) begin
            bit_next = 4'h0;
            oe_next = 1'b1;
            st_next = CDCME_RX;
            if (rw_reg) begin
              tx_next = rdata[15:8];
              lsb_next = rdata[7:0]; // Snapshot, clear-on-read must not empty low byte
              rd_next = (ptr_reg == REG_STATUS);
              oe_next = rdata[15];
              bit_next = 4'h1;
              byte_next = 2'h0;
              st_next = CDCME_TX;
            end
          end
        end
        CDCME_TX: begin
          if (fall) begin
            if (bit_reg == BITS_PER_BYTE) begin
              oe_next = 1'b1;
              st_next = CDCME_RACK;
            end else begin
              tx_next = {tx_reg[6:0], 1'b0};
              oe_next = tx_reg[6];
              bit_next = bit_reg + 4'h1;
            end
          end
        end
        CDCME_RACK: begin
          if (rise) rack_next = sda_s;
          if (fall) begin
            st_next = CDCME_IDLE;
            if (!rack_reg) begin
              tx_next = byte_reg[0] ? rdata[15:8] : lsb_reg;
              oe_next = byte_reg[0] ? rdata[15] : lsb_reg[7];
              if (byte_reg[0]) lsb_next = rdata[7:0];
              rd_next = byte_reg[0] && (ptr_reg == REG_STATUS);
              byte_next = {1'b0, ~byte_reg[0]};
              bit_next = 4'h1;
              st_next = CDCME_TX;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= CDCME_IDLE;
      sh_reg <= 8'h00;
      ptr_reg <= 8'h00;
      msb_reg <= 8'h00;
      tx_reg <= 8'h00;
      lsb_reg <= 8'h00;
      bit_reg <= 4'h0;
      byte_reg <= 2'h0;
      rw_reg <= 1'b0;
      rack_reg <= 1'b1;
      oe_reg <= 1'b1;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      sh_reg <= sh_next;
      ptr_reg <= ptr_next;
      msb_reg <= msb_next;
      tx_reg <= tx_next;
      lsb_reg <= lsb_next;
      bit_reg <= bit_next;
      byte_reg <= byte_next;
      rw_reg <= rw_next;
      rack_reg <= rack_next;
      oe_reg <= oe_next;
      wr_reg <= wr_next;
      rd_reg <= rd_next;
    end
  end

  // Control registers, latched events and mode decoding
  assign err_clr = rd_reg | (result_read & (result_read_chan == echan_reg));
  always_comb begin
    errcfg_next = errcfg_reg;
    config_next = config_reg;
    mux_next = mux_reg;
    if (wr_reg && ptr_reg == REG_ERRCFG) errcfg_next = {msb_reg, sh_reg};
    if (wr_reg && ptr_reg == REG_CONFIG) config_next = {msb_reg, sh_reg};
    if (wr_reg && ptr_reg == REG_MUX) mux_next = {msb_reg, sh_reg};
    rwd_next = rwd_reg;
    ramp_next = ramp_reg;
    if (result_read) begin
      rwd_next[result_read_chan] = 1'b0;
      ramp_next[result_read_chan] = 1'b0;
    end
    if (watchdog_evt && errcfg_reg[WD_TO_RESULT_BIT]) rwd_next[event_chan] = 1'b1;
    if ((amp_high_evt && errcfg_reg[AH_TO_RESULT_BIT]) ||
        (amp_low_evt && errcfg_reg[AL_TO_RESULT_BIT]))
      ramp_next[event_chan] = 1'b1;
    swd_next = err_clr ? 1'b0 : swd_reg;
    latched_next = err_clr ? 1'b0 : latched_reg;
    echan_next = err_clr ? 2'h0 : echan_reg;
    if (watchdog_evt && errcfg_reg[WD_TO_IRQ_BIT]) begin
      swd_next = 1'b1;
      latched_next = 1'b1;
      if (!latched_reg || err_clr) echan_next = event_chan;
    end
    srdy_next = rd_reg ? 1'b0 : srdy_reg;
    if (conv_done && errcfg_reg[RDY_TO_IRQ_BIT] &&
        (!mux_reg[SEQ_EN_BIT] || ch_reg == last_chan(mux_reg[ORDER_HI:ORDER_LO])))
      srdy_next = 1'b1;
    ch_next = config_reg[CHSEL_HI:CHSEL_LO];
    if (mux_reg[SEQ_EN_BIT]) begin
      ch_next = ch_reg;
      if (ch_reg > last_chan(mux_reg[ORDER_HI:ORDER_LO])) ch_next = 2'h0;
      else if (conv_done)
        ch_next = (ch_reg == last_chan(mux_reg[ORDER_HI:ORDER_LO])) ? 2'h0 :
          ch_reg + 2'h1;
    end
    irq_next = ~((swd_next | srdy_next) & ~config_reg[IRQ_MASK_BIT]);
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      errcfg_reg <= ERRCFG_RST;
      config_reg <= CONFIG_RST;
      mux_reg <= MUX_RST;
      rwd_reg <= 4'h0;
      ramp_reg <= 4'h0;
      swd_reg <= 1'b0;
      srdy_reg <= 1'b0;
      latched_reg <= 1'b0;
      echan_reg <= 2'h0;
      ch_reg <= 2'h0;
      irq_reg <= 1'b1;
      sleep_reg <= CONFIG_RST[SLEEP_BIT];
      full_reg <= ~CONFIG_RST[ACT_STYLE_BIT];
      ref_reg <= CONFIG_RST[REF_SRC_BIT];
      boost_reg <= 1'b0;
    end else begin
      errcfg_reg <= errcfg_next;
      config_reg <= config_next;
      mux_reg <= mux_next;
      rwd_reg <= rwd_next;
      ramp_reg <= ramp_next;
      swd_reg <= swd_next;
      srdy_reg <= srdy_next;
      latched_reg <= latched_next;
      echan_reg <= echan_next;
      ch_reg <= ch_next;
      irq_reg <= irq_next;
      sleep_reg <= config_next[SLEEP_BIT];
      full_reg <= ~config_next[ACT_STYLE_BIT];
      ref_reg <= config_next[REF_SRC_BIT];
      boost_reg <= config_next[BOOST_BIT] & ~mux_next[SEQ_EN_BIT];
    end
  end

  // Outputs straight from flops, sda_out tied low
  assign sda_out = 1'b0;
  assign sda_oe_n = oe_reg;
  assign result_watchdog_flag = rwd_reg;
  assign result_amplitude_flag = ramp_reg;
  assign conv_channel = ch_reg;
  assign sleep_active = sleep_reg;
  assign full_current_activation = full_reg;
  assign reference_source_select = ref_reg;
  assign boost_drive_ch0_en = boost_reg;
  assign irq_n_pin = irq_reg;

  // Checks
  sequence wd_seen_s;
    watchdog_evt && errcfg_reg[WD_TO_IRQ_BIT];
  endsequence
  sequence no_clear_s;
    !err_clr;
  endsequence
  wd_result_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    watchdog_evt && !errcfg_reg[WD_TO_RESULT_BIT] && !rwd_reg[event_chan] |=>
    !rwd_reg[$past(event_chan)])
    else $error("watchdog result flag set while disabled");
  amp_result_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    amp_high_evt && errcfg_reg[AH_TO_RESULT_BIT] |=> ramp_reg[$past(event_chan)])
    else $error("amplitude high not reported");
  amp_low_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    amp_low_evt && errcfg_reg[AL_TO_RESULT_BIT] |=> ramp_reg[$past(event_chan)])
    else $error("amplitude low not reported");
  wd_status_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    wd_seen_s and no_clear_s |=> swd_reg && (!irq_n_pin || $past(config_reg[IRQ_MASK_BIT])))
    else $error("watchdog status or interrupt missing");
  rdy_mask_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(srdy_reg) |-> $past(conv_done) && $past(errcfg_reg[RDY_TO_IRQ_BIT]))
    else $error("ready flag without enabled result");
  single_chan_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !mux_reg[SEQ_EN_BIT] [*2] |-> conv_channel == $past(config_reg[CHSEL_HI:CHSEL_LO]))
    else $error("single channel not followed");
  scan_wrap_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    mux_reg[SEQ_EN_BIT] && $stable(mux_reg) && conv_done &&
    ch_reg == last_chan(mux_reg[ORDER_HI:ORDER_LO]) |=> conv_channel == 2'h0)
    else $error("scan did not restart");
  irq_mask_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    config_reg[IRQ_MASK_BIT] && $stable(config_reg) |=> irq_n_pin)
    else $error("masked interrupt asserted");
  err_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    latched_reg && !err_clr |=> echan_reg == $past(echan_reg) && swd_reg)
    else $error("latched error lost");
  sleep_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    sleep_active == config_reg[SLEEP_BIT])
    else $error("sleep state mismatch");
endmodule
`default_nettype wire

// >>> test/cdcme_host_model.sv
// Host side model driving the serial register pins
`default_nettype none
module cdcme_host_model (
  // Clock
  input wire logic ref_clk,
  // Device data pin side
  input wire logic sda_out,
  input wire logic sda_oe_n,
  // Lines seen by the device
  output logic scl_pin,
  output logic sda_in
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PHASE = 6;
  logic scl_drv = 1'b1;
  logic sda_drv = 1'b1;
  // Open-drain data line with pull-up, clock pushed by the host
  assign scl_pin = scl_drv;
  assign sda_in = sda_drv & (sda_oe_n | sda_out);
  task automatic hold();
    repeat (PHASE) @(posedge ref_clk);
  endtask
  // Start or repeated start, ends with clock low
  task automatic start_cond();
    @(posedge ref_clk);
    sda_drv <= 1'b1;
    hold();
    scl_drv <= 1'b1;
    hold();
    sda_drv <= 1'b0;
    hold();
    scl_drv <= 1'b0;
  endtask
  task automatic stop_cond();
    @(posedge ref_clk);
    sda_drv <= 1'b0;
    hold();
    scl_drv <= 1'b1;
    hold();
    sda_drv <= 1'b1;
    hold();
  endtask
  // Data moves one cycle after the clock falls, sampled late in the high phase
  task automatic bit_io(input logic b, output logic r);
    @(posedge ref_clk);
    sda_drv <= b;
    hold();
    scl_drv <= 1'b1;
    hold();
    r = sda_in;
    scl_drv <= 1'b0;
  endtask
  task automatic byte_wr(input logic [7:0] d, inout logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ok = ok & ~r;
  endtask
  task automatic byte_rd(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 0; i < 8; i++) begin
      bit_io(1'b1, r);
      d = {d[6:0], r};
    end
    bit_io(last, r);
  endtask
  // Word write: address, pointer, high byte, low byte
  task automatic write_reg(input logic [6:0] a, input logic [7:0] p, input logic [15:0] w,
                           output logic ok);
    ok = 1'b1;
    start_cond();
    byte_wr({a, 1'b0}, ok);
    byte_wr(p, ok);
    byte_wr(w[15:8], ok);
    byte_wr(w[7:0], ok);
    stop_cond();
  endtask
  // Word read through a repeated start
  task automatic read_reg(input logic [6:0] a, input logic [7:0] p, output logic [15:0] w);
    logic ok;
    ok = 1'b1;
    start_cond();
    byte_wr({a, 1'b0}, ok);
    byte_wr(p, ok);
    start_cond();
    byte_wr({a, 1'b1}, ok);
    byte_rd(1'b0, w[15:8]);
    byte_rd(1'b1, w[7:0]);
    stop_cond();
  endtask
endmodule
`default_nettype wire

// >>> test/cdc_mode_and_error_reporting_tb.sv
// Self-checking bench for the mode and error reporting registers
`default_nettype none
module cdc_mode_and_error_reporting_tb
  import cdcme_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, resetn, scl_pin, sda_in, sda_out, sda_oe_n;
  logic conv_done, watchdog_evt, amp_high_evt, amp_low_evt, result_read;
  logic [1:0] event_chan, result_read_chan, conv_channel;
  logic [3:0] result_watchdog_flag, result_amplitude_flag, m_wd, m_amp;
  logic sleep_active, full_current_activation, reference_source_select;
  logic boost_drive_ch0_en, irq_n_pin, st_wd, st_rdy, err_lat;
  logic [15:0] errcfg, cfg, mux, c;
  logic [1:0] error_source_channel;
  int bad_count, tests_run, seq_ch, last, ch;
  int seed = 32'hd396;
  cdcme_regs #(.BUS_ADDR(BUS_ADDR_DEFAULT)) cdcme_regs_inst (.ref_clk(ref_clk),
    .resetn(resetn), .scl_pin(scl_pin), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .conv_done(conv_done), .watchdog_evt(watchdog_evt),
    .amp_high_evt(amp_high_evt), .amp_low_evt(amp_low_evt), .event_chan(event_chan),
    .result_read(result_read), .result_read_chan(result_read_chan),
    .result_watchdog_flag(result_watchdog_flag), .result_amplitude_flag(result_amplitude_flag),
    .conv_channel(conv_channel), .sleep_active(sleep_active),
    .full_current_activation(full_current_activation),
    .reference_source_select(reference_source_select),
    .boost_drive_ch0_en(boost_drive_ch0_en), .irq_n_pin(irq_n_pin));
  cdcme_host_model cdcme_host_model_inst (.ref_clk(ref_clk), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .scl_pin(scl_pin), .sda_in(sda_in));
  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t word got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t output got %h exp %h", $time, got, exp);
    end
  endtask
  // Register access through the host model, model updated whether or not the write is acknowledged
  task automatic wr(input logic [7:0] p, input logic [15:0] w);
    logic ok;
    cdcme_host_model_inst.write_reg(BUS_ADDR_DEFAULT, p, w, ok);
    chk_out({7'h0, ok}, 8'h01);
    if (p == 8'h19) errcfg = w;
    if (p == 8'h1a) cfg = w;
    if (p == 8'h1b) begin
      mux = w;
      seq_ch = 0;
      last = (w[14:13] == 2'h1) ? 2 : (w[14:13] == 2'h2) ? 3 : 1;
    end
  endtask
  task automatic rd(input logic [7:0] p, input logic [15:0] exp, input logic [15:0] m);
    logic [15:0] got;
    cdcme_host_model_inst.read_reg(BUS_ADDR_DEFAULT, p, got);
    chk_word(got & m, exp & m);
    if (p == 8'h18) {st_wd, st_rdy, err_lat, error_source_channel} = 5'h0;
  endtask
  function automatic logic [15:0] status_exp();
    return {error_source_channel, 2'h0, st_wd, 4'h0, st_rdy, 6'h0};
  endfunction
  // One-cycle event pulse and the model's reaction to it
  task automatic pulse(input int k, input int chn);
    @(posedge ref_clk);
    {result_read, amp_low_evt, amp_high_evt, watchdog_evt, conv_done} <= 5'h01 << k;
    event_chan <= chn[1:0];
    result_read_chan <= chn[1:0];
    @(posedge ref_clk);
    {result_read, amp_low_evt, amp_high_evt, watchdog_evt, conv_done} <= 5'h00;
    case (k)
      0: begin
        if (errcfg[0] && (!mux[15] || seq_ch == last)) st_rdy = 1'b1;
        if (mux[15]) seq_ch = (seq_ch == last) ? 0 : seq_ch + 1;
      end
      1: begin
        if (errcfg[13]) m_wd[chn] = 1'b1;
        if (errcfg[5] && !err_lat) {err_lat, error_source_channel} = {1'b1, chn[1:0]};
        if (errcfg[5]) st_wd = 1'b1;
      end
      2: if (errcfg[12]) m_amp[chn] = 1'b1;
      3: if (errcfg[11]) m_amp[chn] = 1'b1;
      default: begin
        {m_wd[chn], m_amp[chn]} = 2'h0;
        // Reading the erroring channel's result releases the latch
        if (chn[1:0] == error_source_channel) {st_wd, err_lat, error_source_channel} = 4'h0;
      end
    endcase
  endtask
  task automatic check_outs();
    @(posedge ref_clk);
    chk_out({result_watchdog_flag, result_amplitude_flag}, {m_wd, m_amp});
    chk_out({7'h0, irq_n_pin}, {7'h0, !((st_wd | st_rdy) & !cfg[7])});
    chk_out({6'h0, conv_channel}, mux[15] ? 8'(seq_ch) : {6'h0, cfg[15:14]});
    chk_out({4'h0, sleep_active, full_current_activation, reference_source_select,
             boost_drive_ch0_en}, {4'h0, cfg[13], !cfg[11], cfg[9], cfg[6] & !mux[15]});
  endtask
  // Hang guard
  initial begin
    repeat (90000) @(posedge ref_clk);
    bad_count++;
    $display("[ERR] %0t run did not finish", $time);
    final_report();
  end
  // Main sequence
  initial begin
    {resetn, conv_done, watchdog_evt, amp_high_evt, amp_low_evt, result_read} = 6'h0;
    {event_chan, result_read_chan, m_wd, m_amp, st_wd, st_rdy, err_lat, error_source_channel} = 17'h0;
    {errcfg, cfg, mux, seq_ch, last} = {16'h0000, 16'h2801, 16'h020f, 32'd0, 32'd1};
    {bad_count, tests_run} = 64'd0;
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    check_outs();
    rd(8'h19, errcfg, 16'hffff);
    rd(8'h1a, cfg, 16'hffff);
    rd(8'h1b, mux, 16'hffff);
    wr(8'h30, 16'h1234);
    rd(8'h30, 16'h0000, 16'hffff);
    cdcme_host_model_inst.write_reg(7'h2b, 8'h19, 16'h2000, c[0]);
    chk_out({7'h0, c[0]}, 8'h00);
    rd(8'h19, errcfg, 16'hffff);
    $display("reset and access test done");
    // Random mode settings with the fixed setup pattern kept
    repeat (6) begin
      wr(8'h1a, 16'h1401 | (16'($random(seed)) & 16'heac0));
      rd(8'h1a, cfg, 16'hffff);
      check_outs();
    end
    $display("mode test done");
    // Every scan order code, boost left off while sequencing
    wr(8'h1a, 16'h1401);
    wr(8'h19, 16'h0001);
    rd(8'h18, 16'h0000, 16'h0000);
    for (int code = 0; code < 4; code++) begin
      wr(8'h1b, 16'h020f);
      wr(8'h1b, {1'b1, 2'(code), 13'h020f});
      repeat (8) begin
        pulse(0, 0);
        check_outs();
      end
      rd(8'h18, status_exp(), 16'h0040);
      check_outs();
    end
    wr(8'h1b, 16'h020f);
    $display("sequencing test done");
    // Every combination of the result and watchdog interrupt enables, with all event kinds
    for (int i = 0; i < 16; i++) begin
      wr(8'h19, {2'h0, i[0], i[1], i[2], 5'h0, i[3], 4'h0, ~(i[3] ^ i[0])});
      wr(8'h1a, 16'h1401 | (16'($random(seed)) & 16'hc080));
      ch = $random(seed) & 3;
      pulse(1, ch);
      pulse(2, (ch + 1) % 4);
      pulse(3, (ch + 2) % 4);
      check_outs();
      pulse(0, 0);
      check_outs();
      rd(8'h18, status_exp(), 16'h0840);
      check_outs();
      for (int k = 0; k < 4; k++) pulse(4, k);
      check_outs();
    end
    $display("event test done");
    // First error channel holds over a later one
    wr(8'h1a, 16'h1401);
    wr(8'h19, 16'h2021);
    pulse(1, 2);
    pulse(1, 1);
    check_outs();
    rd(8'h18, status_exp(), 16'hc840);
    check_outs();
    pulse(1, 3);
    pulse(4, 3);
    check_outs();
    rd(8'h18, status_exp(), 16'hc840);
    $display("error latch test done");
    final_report();
  end
endmodule
`default_nettype wire
